// >>> chm_irq_clear_mask.sv
// Purpose: Sticky status flags, write-one clear and interrupt mask over APB
// Assumes: Event pulses and live levels come from logic on core_clk
// Notes:   Every APB access waits one cycle; outputs are registered
module chm_irq_clear_mask
    import chm_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        core_ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic        completion_signal_set,
    input  wire logic        card_interrupt_set,
    input  wire logic        block_end_set,
    input  wire logic        start_bit_error_set,
    input  wire logic        transfer_end_set,
    input  wire logic        command_sent_set,
    input  wire logic        response_received_set,
    input  wire logic        receive_overrun_set,
    input  wire logic        transmit_underrun_set,
    input  wire logic        data_timeout_set,
    input  wire logic        command_timeout_set,
    input  wire logic        data_crc_fail_set,
    input  wire logic        command_crc_fail_set,
    input  wire logic        receive_data_available,
    input  wire logic        transmit_data_available,
    input  wire logic        receive_fifo_empty,
    input  wire logic        transmit_fifo_empty,
    input  wire logic        receive_fifo_full,
    input  wire logic        transmit_fifo_full,
    input  wire logic        receive_fifo_half_full,
    input  wire logic        transmit_fifo_half_empty,
    input  wire logic        receive_in_progress,
    input  wire logic        transmit_in_progress,
    input  wire logic        command_in_progress
);

    logic        completion_signal_flag_reg;
    logic        card_interrupt_flag_reg;
    logic        block_end_flag_reg;
    logic        start_bit_error_flag_reg;
    logic        transfer_end_flag_reg;
    logic        command_sent_flag_reg;
    logic        response_received_flag_reg;
    logic        receive_overrun_flag_reg;
    logic        transmit_underrun_flag_reg;
    logic        data_timeout_flag_reg;
    logic        command_timeout_flag_reg;
    logic        data_crc_fail_flag_reg;
    logic        command_crc_fail_flag_reg;
    logic        completion_signal_next;
    logic        card_interrupt_next;
    logic        block_end_next;
    logic        start_bit_error_next;
    logic        transfer_end_next;
    logic        command_sent_next;
    logic        response_received_next;
    logic        receive_overrun_next;
    logic        transmit_underrun_next;
    logic        data_timeout_next;
    logic        command_timeout_next;
    logic        data_crc_fail_next;
    logic        command_crc_fail_next;

    logic [31:0] interrupt_enable_mask_reg;
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic        irq_reg;
    logic [31:0] live_vec;
    logic [31:0] live_flags_reg;
    logic [31:0] status_word;
    logic [31:0] clear_vec;
    logic [31:0] mask_wdata;
    logic        access_done;
    logic        wr_done;
    chm_sel_e    sel;

    // Byte-lane merge, shared by every writable word
    function automatic logic [31:0] chm_merge(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic chm_sel_e chm_decode(input logic [7:0] addr);
        chm_sel_e s;
        s = CHM_SEL_NONE;
        case (addr)
            CHM_OFS_STATUS: s = CHM_SEL_STATUS;
            CHM_OFS_CLEAR:  s = CHM_SEL_CLEAR;
            CHM_OFS_MASK:   s = CHM_SEL_MASK;
            default:        s = CHM_SEL_NONE;
        endcase
        return s;
    endfunction

    assign sel         = chm_decode(paddr);
    assign access_done = psel & penable & pready_reg;
    assign wr_done     = access_done & pwrite;

    // Set is applied after the clear, so an event in the clearing cycle survives
    function automatic logic chm_sticky(
        input logic old_flag,
        input logic set_flag,
        input logic clr_flag
    );
        return (old_flag & ~clr_flag) | set_flag;
    endfunction

    always_comb begin
        completion_signal_next = chm_sticky(completion_signal_flag_reg,
            completion_signal_set, clear_vec[CHM_B_COMPLETION]);
        card_interrupt_next = chm_sticky(card_interrupt_flag_reg,
            card_interrupt_set, clear_vec[CHM_B_CARD_IRQ]);
        block_end_next = chm_sticky(block_end_flag_reg,
            block_end_set, clear_vec[CHM_B_BLOCK_END]);
        start_bit_error_next = chm_sticky(start_bit_error_flag_reg,
            start_bit_error_set, clear_vec[CHM_B_START_BIT_ERR]);
        transfer_end_next = chm_sticky(transfer_end_flag_reg,
            transfer_end_set, clear_vec[CHM_B_TRANSFER_END]);
        command_sent_next = chm_sticky(command_sent_flag_reg,
            command_sent_set, clear_vec[CHM_B_CMD_SENT]);
        response_received_next = chm_sticky(response_received_flag_reg,
            response_received_set, clear_vec[CHM_B_RESP_RECEIVED]);
        receive_overrun_next = chm_sticky(receive_overrun_flag_reg,
            receive_overrun_set, clear_vec[CHM_B_RX_OVERRUN]);
        transmit_underrun_next = chm_sticky(transmit_underrun_flag_reg,
            transmit_underrun_set, clear_vec[CHM_B_TX_UNDERRUN]);
        data_timeout_next = chm_sticky(data_timeout_flag_reg,
            data_timeout_set, clear_vec[CHM_B_DATA_TIMEOUT]);
        command_timeout_next = chm_sticky(command_timeout_flag_reg,
            command_timeout_set, clear_vec[CHM_B_CMD_TIMEOUT]);
        data_crc_fail_next = chm_sticky(data_crc_fail_flag_reg,
            data_crc_fail_set, clear_vec[CHM_B_DATA_CRC_FAIL]);
        command_crc_fail_next = chm_sticky(command_crc_fail_flag_reg,
            command_crc_fail_set, clear_vec[CHM_B_CMD_CRC_FAIL]);
    end

    always_comb begin
        live_vec                      = 32'h0000_0000;
        live_vec[CHM_B_RX_AVAIL]      = receive_data_available;
        live_vec[CHM_B_TX_AVAIL]      = transmit_data_available;
        live_vec[CHM_B_RX_EMPTY]      = receive_fifo_empty;
        live_vec[CHM_B_TX_EMPTY]      = transmit_fifo_empty;
        live_vec[CHM_B_RX_FULL]       = receive_fifo_full;
        live_vec[CHM_B_TX_FULL]       = transmit_fifo_full;
        live_vec[CHM_B_RX_HALF_FULL]  = receive_fifo_half_full;
        live_vec[CHM_B_TX_HALF_EMPTY] = transmit_fifo_half_empty;
        live_vec[CHM_B_RX_ACTIVE]     = receive_in_progress;
        live_vec[CHM_B_TX_ACTIVE]     = transmit_in_progress;
        live_vec[CHM_B_CMD_ACTIVE]    = command_in_progress;
    end

    // Clear command: only ones act, and only on static positions
    always_comb begin
        clear_vec = 32'h0000_0000;
        if (wr_done && sel == CHM_SEL_CLEAR) begin
            clear_vec = chm_merge(32'h0000_0000, pwdata, pstrb) & CHM_STATIC_BITS;
        end
    end

    // One flop per sticky flag; each one is cleared only by its own clear bit
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            completion_signal_flag_reg <= CHM_STATUS_RST[CHM_B_COMPLETION];
        end else if (core_ce) begin
            completion_signal_flag_reg <= completion_signal_next;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            card_interrupt_flag_reg <= CHM_STATUS_RST[CHM_B_CARD_IRQ];
        end else if (core_ce) begin
            card_interrupt_flag_reg <= card_interrupt_next;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            block_end_flag_reg <= CHM_STATUS_RST[CHM_B_BLOCK_END];
        end else if (core_ce) begin
            block_end_flag_reg <= block_end_next;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_bit_error_flag_reg <= CHM_STATUS_RST[CHM_B_START_BIT_ERR];
        end else if (core_ce) begin
            start_bit_error_flag_reg <= start_bit_error_next;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            transfer_end_flag_reg <= CHM_STATUS_RST[CHM_B_TRANSFER_END];
        end else if (core_ce) begin
            transfer_end_flag_reg <= transfer_end_next;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            command_sent_flag_reg <= CHM_STATUS_RST[CHM_B_CMD_SENT];
        end else if (core_ce) begin
            command_sent_flag_reg <= command_sent_next;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            response_received_flag_reg <= CHM_STATUS_RST[CHM_B_RESP_RECEIVED];
        end else if (core_ce) begin
            response_received_flag_reg <= response_received_next;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            receive_overrun_flag_reg <= CHM_STATUS_RST[CHM_B_RX_OVERRUN];
        end else if (core_ce) begin
            receive_overrun_flag_reg <= receive_overrun_next;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            transmit_underrun_flag_reg <= CHM_STATUS_RST[CHM_B_TX_UNDERRUN];
        end else if (core_ce) begin
            transmit_underrun_flag_reg <= transmit_underrun_next;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_timeout_flag_reg <= CHM_STATUS_RST[CHM_B_DATA_TIMEOUT];
        end else if (core_ce) begin
            data_timeout_flag_reg <= data_timeout_next;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            command_timeout_flag_reg <= CHM_STATUS_RST[CHM_B_CMD_TIMEOUT];
        end else if (core_ce) begin
            command_timeout_flag_reg <= command_timeout_next;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_crc_fail_flag_reg <= CHM_STATUS_RST[CHM_B_DATA_CRC_FAIL];
        end else if (core_ce) begin
            data_crc_fail_flag_reg <= data_crc_fail_next;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            command_crc_fail_flag_reg <= CHM_STATUS_RST[CHM_B_CMD_CRC_FAIL];
        end else if (core_ce) begin
            command_crc_fail_flag_reg <= command_crc_fail_next;
        end
    end

    // Live levels are registered once and never held, so they cannot be cleared
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            live_flags_reg <= CHM_STATUS_RST;
        end else if (core_ce) begin
            live_flags_reg <= live_vec & CHM_DYNAMIC_BITS;
        end
    end

    always_comb begin
        status_word                       = live_flags_reg;
        status_word[CHM_B_COMPLETION]     = completion_signal_flag_reg;
        status_word[CHM_B_CARD_IRQ]       = card_interrupt_flag_reg;
        status_word[CHM_B_BLOCK_END]      = block_end_flag_reg;
        status_word[CHM_B_START_BIT_ERR]  = start_bit_error_flag_reg;
        status_word[CHM_B_TRANSFER_END]   = transfer_end_flag_reg;
        status_word[CHM_B_CMD_SENT]       = command_sent_flag_reg;
        status_word[CHM_B_RESP_RECEIVED]  = response_received_flag_reg;
        status_word[CHM_B_RX_OVERRUN]     = receive_overrun_flag_reg;
        status_word[CHM_B_TX_UNDERRUN]    = transmit_underrun_flag_reg;
        status_word[CHM_B_DATA_TIMEOUT]   = data_timeout_flag_reg;
        status_word[CHM_B_CMD_TIMEOUT]    = command_timeout_flag_reg;
        status_word[CHM_B_DATA_CRC_FAIL]  = data_crc_fail_flag_reg;
        status_word[CHM_B_CMD_CRC_FAIL]   = command_crc_fail_flag_reg;
    end

    assign mask_wdata = chm_merge(interrupt_enable_mask_reg, pwdata, pstrb) & CHM_MASK_BITS;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_enable_mask_reg <= CHM_MASK_RST;
        end else if (core_ce && wr_done && sel == CHM_SEL_MASK) begin
            interrupt_enable_mask_reg <= mask_wdata;
        end
    end

    // One wait state gives registered read data without a combinational path
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_reg <= 1'b0;
        end else if (core_ce) begin
            pready_reg <= psel & penable & ~pready_reg;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (core_ce) begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
            if (psel && penable && !pready_reg) begin
                case (sel)
                    CHM_SEL_STATUS: begin
                        pslverr_reg <= pwrite;
                        if (!pwrite) begin
                            prdata_reg <= status_word;
                        end
                    end
                    CHM_SEL_CLEAR: begin
                        // Write-only: a read returns zero and holds no state
                        prdata_reg <= 32'h0000_0000;
                    end
                    CHM_SEL_MASK: begin
                        if (!pwrite) begin
                            prdata_reg <= interrupt_enable_mask_reg;
                        end
                    end
                    default: begin
                        pslverr_reg <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Mask positions match status positions, so one AND covers every pair
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_reg <= 1'b0;
        end else if (core_ce) begin
            irq_reg <= |(status_word & interrupt_enable_mask_reg);
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq     = irq_reg;

endmodule

// >>> chm_irq_clear_mask_assertions.sv
// Purpose: Port-level checks for the card host flag-clear and mask block
// Assumes: Full-word mask writes; core_ce high
// Notes:   mask_sh mirrors the mask from completed APB writes
module chm_irq_clear_mask_assertions
    import chm_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        core_ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq,
    input wire logic        command_crc_fail_set,
    input wire logic        command_in_progress
);
    logic [31:0] mask_sh;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_sh <= CHM_MASK_RST;
        end else if (core_ce && psel && penable && pready && pwrite && paddr == CHM_OFS_MASK) begin
            mask_sh <= pwdata & CHM_MASK_BITS;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence setup_s; psel && !penable && core_ce; endsequence
    sequence access_s; psel && penable && core_ce; endsequence
    one_wait_a: assert property (setup_s ##1 access_s |=> pready)
        else $error("ready not after one wait state");
    ready_pulse_a: assert property (pready && core_ce |=> !pready)
        else $error("ready longer than one cycle");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    clear_reads_zero_a: assert property (pready && !pwrite && paddr == CHM_OFS_CLEAR |-> prdata == 32'h0 && !pslverr)
        else $error("clear register read not zero");
    mask_readback_a: assert property (pready && !pwrite && paddr == CHM_OFS_MASK |-> prdata == mask_sh)
        else $error("mask readback wrong");
    masked_quiet_a: assert property ((mask_sh == 32'h0) [*2] |-> !irq)
        else $error("interrupt with all masked");
    sticky_irq_a: assert property (command_crc_fail_set && mask_sh[0] ##1 mask_sh[0] |=> irq)
        else $error("flagged event gave no interrupt");
    live_irq_a: assert property (command_in_progress && mask_sh[11] ##1 mask_sh[11] |=> irq)
        else $error("live level gave no interrupt");
endmodule
bind chm_irq_clear_mask chm_irq_clear_mask_assertions chk_u (
    .core_clk, .rst_n, .core_ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .command_crc_fail_set, .command_in_progress);

// >>> chm_irq_clear_mask_tb.sv
// Purpose: Self-checking bench for the card host flag-clear and mask block
// Assumes: Set pulse timing in the race test follows the one wait state
// Notes:   Strobes stay all-on, so partial writes are not exercised
module chm_irq_clear_mask_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import chm_pkg::*;
    logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, rerr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [23:0] ev;
    int          fails, checked;
    chm_irq_clear_mask dut (
        .core_clk, .rst_n, .core_ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb(4'hf), .prdata, .pready, .pslverr, .irq,
        .completion_signal_set(ev[23]), .card_interrupt_set(ev[22]),
        .block_end_set(ev[10]), .start_bit_error_set(ev[9]), .transfer_end_set(ev[8]),
        .command_sent_set(ev[7]), .response_received_set(ev[6]),
        .receive_overrun_set(ev[5]), .transmit_underrun_set(ev[4]),
        .data_timeout_set(ev[3]), .command_timeout_set(ev[2]),
        .data_crc_fail_set(ev[1]), .command_crc_fail_set(ev[0]),
        .receive_data_available(ev[21]), .transmit_data_available(ev[20]),
        .receive_fifo_empty(ev[19]), .transmit_fifo_empty(ev[18]),
        .receive_fifo_full(ev[17]), .transmit_fifo_full(ev[16]),
        .receive_fifo_half_full(ev[15]), .transmit_fifo_half_empty(ev[14]),
        .receive_in_progress(ev[13]), .transmit_in_progress(ev[12]),
        .command_in_progress(ev[11]));
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task automatic close_out();
        if (fails == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // Ready, data and error are taken at the rising edge that completes the access
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdat = prdata;
        rerr = pslverr;
        if (pready !== 1'b1) begin
            fails++;
            $display("MISMATCH at %0t: no ready", $time);
            close_out();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    initial begin
        {psel, penable, pwrite, rst_n} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ev = 24'h0;
        fails = 0;
        checked = 0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        apb(1'b0, CHM_OFS_MASK, 32'h0);
        chk(rdat, CHM_MASK_RST);
        apb(1'b0, CHM_OFS_CLEAR, 32'h0);
        chk({rdat[31:1], rerr}, 32'h0);
        for (int i = 0; i < 24; i++) begin
            @(posedge core_clk);
            ev[i] <= 1'b1;
            @(posedge core_clk);
            ev[i] <= ~CHM_STATIC_BITS[i];
            wt(2);
            chk({31'h0, irq}, 32'h0);
            apb(1'b0, CHM_OFS_STATUS, 32'h0);
            chk(rdat, 32'h1 << i);
            apb(1'b1, CHM_OFS_MASK, 32'h1 << i);
            wt(2);
            chk({31'h0, irq}, 32'h1);
            apb(1'b1, CHM_OFS_CLEAR, ~(32'h1 << i));
            apb(1'b0, CHM_OFS_STATUS, 32'h0);
            chk(rdat, 32'h1 << i);
            @(posedge core_clk);
            ev[i] <= 1'b0;
            apb(1'b1, CHM_OFS_CLEAR, 32'h1 << i);
            wt(2);
            chk({31'h0, irq}, 32'h0);
        end
        apb(1'b1, CHM_OFS_MASK, 32'hffff_ffff);
        apb(1'b0, CHM_OFS_MASK, 32'h0);
        chk(rdat, CHM_MASK_BITS);
        // Set pulse lands on the very edge that completes the clear
        fork
            apb(1'b1, CHM_OFS_CLEAR, 32'h1);
            begin
                repeat (3) @(posedge core_clk);
                ev[0] <= 1'b1;
                @(posedge core_clk);
                ev[0] <= 1'b0;
            end
        join
        apb(1'b0, CHM_OFS_STATUS, 32'h0);
        chk(rdat, 32'h1);
        wt(1);
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, 8'h40, 32'h0);
        chk({rdat[31:1], rerr}, 32'h1);
        apb(1'b1, CHM_OFS_STATUS, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        apb(1'b0, CHM_OFS_STATUS, 32'h0);
        chk(rdat, 32'h1);
        // Reset in mid-run must drop the mask and every sticky flag
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        apb(1'b0, CHM_OFS_MASK, 32'h0);
        chk(rdat, CHM_MASK_RST);
        apb(1'b0, CHM_OFS_STATUS, 32'h0);
        chk(rdat, CHM_STATUS_RST);
        wt(1);
        chk({31'h0, irq}, 32'h0);
        close_out();
    end
endmodule

// >>> chm_pkg.sv
// Purpose: Constants for the card host flag-clear and interrupt-mask block
// Assumes: APB slave with 32-bit data, one clock, async active-low reset
// Notes:   Offsets are byte addresses of aligned words
// Contract
// - Clear register at 0x38 is write-only
// - Writing one clears flag, zero keeps it
// - Clear bits 31:24 and 21:11 ignored
// - Clear bits 23, 22 reset completion, card-interrupt
// - Clear bits 10..8 reset block-end, start-error, end
// - Clear bits 7, 6 reset sent, response flags
// - Clear bits 5..0 reset error and timeout flags
// - Mask at 0x3C, read/write, gates each flag
// - Mask bits 23, 22 enable completion, card-interrupt
// - Mask bits 21, 20 enable FIFO data available
// - Mask bits 19..14 enable FIFO level interrupts
// - Mask bits 13..11 enable activity interrupts
// - Mask bits 10..6 enable block, data, command events
// - Mask bits 5..1 enable error and timeout interrupts
// - Mask bit 0 enables command CRC failure
// - Static flags sticky; dynamic flags follow live logic
package chm_pkg;

    localparam logic [7:0]  CHM_OFS_STATUS   = 8'h34;
    localparam logic [7:0]  CHM_OFS_CLEAR    = 8'h38;
    localparam logic [7:0]  CHM_OFS_MASK     = 8'h3c;

    localparam logic [31:0] CHM_STATIC_BITS  = 32'h00c0_07ff;
    localparam logic [31:0] CHM_DYNAMIC_BITS = 32'h003f_f800;
    localparam logic [31:0] CHM_MASK_BITS    = 32'h00ff_ffff;

    localparam logic [31:0] CHM_STATUS_RST   = 32'h0000_0000;
    localparam logic [31:0] CHM_MASK_RST     = 32'h0000_0000;

    // Flag positions in the status, clear and mask words
    localparam int CHM_B_CMD_CRC_FAIL   = 0;
    localparam int CHM_B_DATA_CRC_FAIL  = 1;
    localparam int CHM_B_CMD_TIMEOUT    = 2;
    localparam int CHM_B_DATA_TIMEOUT   = 3;
    localparam int CHM_B_TX_UNDERRUN    = 4;
    localparam int CHM_B_RX_OVERRUN     = 5;
    localparam int CHM_B_RESP_RECEIVED  = 6;
    localparam int CHM_B_CMD_SENT       = 7;
    localparam int CHM_B_TRANSFER_END   = 8;
    localparam int CHM_B_START_BIT_ERR  = 9;
    localparam int CHM_B_BLOCK_END      = 10;
    localparam int CHM_B_CMD_ACTIVE     = 11;
    localparam int CHM_B_TX_ACTIVE      = 12;
    localparam int CHM_B_RX_ACTIVE      = 13;
    localparam int CHM_B_TX_HALF_EMPTY  = 14;
    localparam int CHM_B_RX_HALF_FULL   = 15;
    localparam int CHM_B_TX_FULL        = 16;
    localparam int CHM_B_RX_FULL        = 17;
    localparam int CHM_B_TX_EMPTY       = 18;
    localparam int CHM_B_RX_EMPTY       = 19;
    localparam int CHM_B_TX_AVAIL       = 20;
    localparam int CHM_B_RX_AVAIL       = 21;
    localparam int CHM_B_CARD_IRQ       = 22;
    localparam int CHM_B_COMPLETION     = 23;

    typedef enum logic [1:0] {
        CHM_SEL_NONE,
        CHM_SEL_STATUS,
        CHM_SEL_CLEAR,
        CHM_SEL_MASK
    } chm_sel_e;

endpackage
